// ### hw/rtcc_core.sv
// Command interpreter, broadcast mode and check-value logic of the tag
// Notes on behaviour
// - Error-free record write in ready state stores 128 bits and answers.
// - Record content is never checked against the animal-ID format.
// - Reader supplies the record as broadcast; the tag replays it unchanged.
// - Code 111000 writes; code 111001 writes then locks the record until the next reset.
// - A written record is broadcast only after the next field entry.
// - Successful write answers error bit 0, then the check value when the append flag is set.
// - Error-free system-information request (optional 48-bit UNIQUE_TAG_IDENTIFIER) returns system data.
// - System answer: error bit, 40-bit serial, maker, chip reference, six zero bytes.
// - Login compares 32-bit secret with stored one; match grants write, optionally read.
// - A later login with a wrong secret removes all protected access.
// - On field entry the tag broadcasts its record without any command.
// - Switch command or start-of-frame in the listening window enters reader mode.
// - Every request is checked for errors before it is executed.
// - Check value uses polynomial 1021h with preset 0000h.
// - Check value runs over all request bits; answer appends one when flag set.
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ns
`default_nettype none
module rtcc_core
    import rtcc_pkg::*;
#(
    parameter int unsigned LISTEN_CYC = LISTEN_CYCLES,
    parameter logic [39:0] SERIAL_NUMBER_FIELD = 40'h0000000001, // Arbitrary value
    parameter logic [7:0] MAKER_CODE_FIELD = 8'h5a, // Arbitrary value
    parameter logic [7:0] CHIP_REFERENCE_FIELD = 8'h01, // Arbitrary value
    parameter logic [127:0] RECORD_INIT = RECORD_DEFAULT
)
(
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic field_entry_in,
    input wire logic sof_in,
    input wire logic eof_in,
    input wire logic rx_bit_valid_in,
    input wire logic rx_bit_in,
    input wire logic tx_next_in,
    input wire logic [4:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    output logic tx_active_out,
    output logic tx_bit_out,
    output logic broadcast_mode_out,
    output logic access_write_out,
    output logic access_read_out,
    output logic record_locked_out,
    output logic irq_out
);
    localparam logic [47:0] UNIQUE_TAG_IDENTIFIER = {SERIAL_NUMBER_FIELD, MAKER_CODE_FIELD};
    localparam logic [19:0] LISTEN_LOAD = 20'(LISTEN_CYC);

    logic [1:0] rst_sync_r;
    logic rst_n;
    rtcc_st_type r;
    rtcc_st_type r_nxt;

    function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic b);
        crc_step = {crc[14:0], 1'b0} ^ ((crc[15] ^ b) ? CRC_POLY : 16'h0000);
    endfunction : crc_step

    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            rst_sync_r <= 2'b00;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    always_comb
    begin
        logic [143:0] pl_eff;
        logic uid_on;
        logic crc_on;
        logic [5:0] cmd;
        logic [7:0] exp_len;
        logic known;
        logic err;
        logic uid_ok;
        logic tx_b;
        logic [15:0] crc_new;
        logic [3:0] ev;
        pl_eff = '0;
        uid_on = 1'b0;
        crc_on = 1'b0;
        cmd = 6'h00;
        exp_len = 8'h00;
        known = 1'b0;
        err = 1'b0;
        uid_ok = 1'b1;
        tx_b = 1'b0;
        crc_new = 16'h0000;
        ev = 4'h0;
        r_nxt = r;

        // Response and broadcast shifter
        if (r.tx_act && tx_next_in)
        begin
            tx_b = r.tx_sh[127];
            crc_new = r.tx_crc_ph ? r.tx_crc : crc_step(r.tx_crc, tx_b);
            r_nxt.tx_crc = crc_new;
            r_nxt.tx_sh = {r.tx_sh[126:0], 1'b0};
            r_nxt.tx_cnt = r.tx_cnt - 8'h01;
            if (r.tx_cnt == 8'h01)
            begin
                if (r.tx_app && !r.tx_crc_ph)
                begin
                    r_nxt.tx_sh = {crc_new, 112'h0};
                    r_nxt.tx_cnt = LEN_CRC;
                    r_nxt.tx_crc_ph = 1'b1;
                end
                else
                begin
                    r_nxt.tx_act = 1'b0;
                    if (r.mode == MODE_BCAST_TX)
                    begin
                        r_nxt.mode = MODE_LISTEN;
                        r_nxt.listen_cnt = LISTEN_LOAD;
                    end
                    else
                        r_nxt.mode = MODE_READER_IDLE;
                end
            end
        end

        unique case (r.mode)
            MODE_BCAST_TX:
            begin
            end
            MODE_LISTEN:
            begin
                if (sof_in)
                begin
                    r_nxt.mode = MODE_READER_IDLE;
                    r_nxt.bcast = 1'b0;
                    ev[EV_MODE_SWITCH] = 1'b1;
                end
                else if (r.listen_cnt <= 20'h00001)
                begin
                    r_nxt.mode = MODE_BCAST_TX;
                    r_nxt.tx_sh = r.shadow;
                    r_nxt.tx_cnt = LEN_BCAST_TX;
                    r_nxt.tx_crc = CRC_PRESET;
                    r_nxt.tx_crc_ph = 1'b0;
                    r_nxt.tx_app = 1'b0;
                    r_nxt.tx_act = 1'b1;
                end
                else
                    r_nxt.listen_cnt = r.listen_cnt - 20'h00001;
            end
            MODE_READER_IDLE:
            begin
                if (r.rx_open && rx_bit_valid_in)
                begin
                    r_nxt.rx_crc = crc_step(r.rx_crc, rx_bit_in);
                    if (r.rx_cnt >= MAX_REQ_BITS)
                        r_nxt.rx_ovf = 1'b1;
                    else
                    begin
                        r_nxt.rx_cnt = r.rx_cnt + 8'h01;
                        if (r.rx_cnt < LEN_HDR)
                            r_nxt.hdr = {r.hdr[9:0], rx_bit_in};
                        else
                            r_nxt.pl = {r.pl[142:0], rx_bit_in};
                    end
                end
                if (r.rx_open && eof_in)
                begin
                    r_nxt.rx_open = 1'b0;
                    r_nxt.mode = MODE_EXEC;
                end
            end
            MODE_EXEC:
            begin
                uid_on = r.hdr[FLAG_UID_POS];
                crc_on = r.hdr[FLAG_CRC_POS];
                cmd = r.hdr[5:0];
                pl_eff = crc_on ? (r.pl >> 16) : r.pl;
                exp_len = LEN_HDR + (uid_on ? LEN_UID : 8'h00) + (crc_on ? LEN_CRC : 8'h00);
                known = 1'b1;
                if (cmd == CMD_WRITE_RECORD || cmd == CMD_WRITE_RECORD_LOCK)
                    exp_len = exp_len + LEN_RECORD;
                else if (cmd == CMD_LOGIN)
                begin
                    exp_len = exp_len + LEN_LOGIN;
                    uid_ok = !uid_on || (pl_eff[79:32] == UNIQUE_TAG_IDENTIFIER);
                    if ((uid_on ? pl_eff[87:80] : pl_eff[39:32]) != MAKER_CODE_FIELD)
                        uid_ok = 1'b0;
                end
                else if (cmd == CMD_SYSTEM_INFO)
                    uid_ok = !uid_on || (pl_eff[47:0] == UNIQUE_TAG_IDENTIFIER);
                else if (cmd != CMD_MODE_SWITCH)
                    known = 1'b0;
                // Check before executing: length, check value, command, address
                err = r.rx_ovf || (r.rx_cnt != exp_len) || !known || !uid_ok;
                if (crc_on && r.rx_crc != 16'h0000)
                    err = 1'b1;
                if ((cmd == CMD_WRITE_RECORD || cmd == CMD_WRITE_RECORD_LOCK)
                    && (uid_on || r.nvm_locked))
                    err = 1'b1;
                r_nxt.mode = MODE_RESPOND;
                r_nxt.tx_sh = {1'b1, 127'h0};
                r_nxt.tx_cnt = LEN_STATUS_TX;
                r_nxt.tx_crc = CRC_PRESET;
                r_nxt.tx_crc_ph = 1'b0;
                r_nxt.tx_app = r.check_append_flag;
                r_nxt.tx_act = 1'b1;
                if (err)
                    ev[EV_REQ_ERROR] = 1'b1;
                else if (cmd == CMD_MODE_SWITCH)
                begin
                    r_nxt.mode = MODE_READER_IDLE;
                    r_nxt.tx_act = 1'b0;
                end
                else if (cmd == CMD_WRITE_RECORD || cmd == CMD_WRITE_RECORD_LOCK)
                begin
                    r_nxt.nvm_record = pl_eff[127:0];
                    r_nxt.nvm_locked = (cmd == CMD_WRITE_RECORD_LOCK);
                    r_nxt.tx_sh = {1'b0, 127'h0};
                    ev[EV_WRITE_DONE] = 1'b1;
                end
                else if (cmd == CMD_SYSTEM_INFO)
                begin
                    r_nxt.tx_sh = {1'b0, SERIAL_NUMBER_FIELD, MAKER_CODE_FIELD,
                        CHIP_REFERENCE_FIELD, 48'h0, 23'h0};
                    r_nxt.tx_cnt = LEN_SYSINFO_TX;
                end
                else if (pl_eff[31:0] == r.stored_secret)
                begin
                    r_nxt.acc_wr = 1'b1;
                    r_nxt.acc_rd = r.ctl_grant_read;
                    r_nxt.tx_sh = {1'b0, 127'h0};
                    ev[EV_LOGIN_OK] = 1'b1;
                end
                else
                begin
                    r_nxt.acc_wr = 1'b0;
                    r_nxt.acc_rd = 1'b0;
                    ev[EV_REQ_ERROR] = 1'b1;
                end
            end
            MODE_RESPOND:
            begin
            end
        endcase

        // Start-of-frame opens a request frame in reader mode
        if (sof_in && (r.mode == MODE_READER_IDLE || r.mode == MODE_LISTEN))
        begin
            r_nxt.rx_open = 1'b1;
            r_nxt.rx_ovf = 1'b0;
            r_nxt.rx_cnt = 8'h00;
            r_nxt.hdr = '0;
            r_nxt.pl = '0;
            r_nxt.rx_crc = CRC_PRESET;
        end

        // Field entry restarts the protocol and loads the broadcast copy
        if (field_entry_in)
        begin
            r_nxt.mode = MODE_BCAST_TX;
            r_nxt.shadow = r.nvm_record;
            r_nxt.tx_sh = r.nvm_record;
            r_nxt.tx_cnt = LEN_BCAST_TX;
            r_nxt.tx_crc = CRC_PRESET;
            r_nxt.tx_crc_ph = 1'b0;
            r_nxt.tx_app = 1'b0;
            r_nxt.tx_act = 1'b1;
            r_nxt.rx_open = 1'b0;
            r_nxt.acc_wr = 1'b0;
            r_nxt.acc_rd = 1'b0;
            r_nxt.bcast = 1'b1;
        end

        // Register writes
        if (reg_wr_in)
        begin
            if (reg_addr_in == REG_CONTROL)
            begin
                r_nxt.check_append_flag = reg_wdata_in[CTL_CHECK_APPEND];
                r_nxt.ctl_grant_read = reg_wdata_in[CTL_GRANT_READ];
            end
            if (reg_addr_in == REG_IRQ_ENABLE)
                r_nxt.ien = reg_wdata_in[3:0];
        end
        // Events win over a clear in the same cycle
        r_nxt.sts = (r.sts & ~((reg_wr_in && reg_addr_in == REG_IRQ_CLEAR) ?
            reg_wdata_in[3:0] : 4'h0)) | ev;
        r_nxt.irq = |(r_nxt.sts & r_nxt.ien);

        // Register reads: data stand in the following cycle only
        r_nxt.rdata = 32'h0;
        if (reg_rd_in)
        begin
            if (reg_addr_in == REG_CONTROL)
                r_nxt.rdata = {30'h0, r.ctl_grant_read, r.check_append_flag};
            else if (reg_addr_in == REG_STATUS)
                r_nxt.rdata = {28'h0, r.sts};
            else if (reg_addr_in == REG_IRQ_ENABLE)
                r_nxt.rdata = {28'h0, r.ien};
            else if (reg_addr_in == REG_STATE)
                r_nxt.rdata = {24'h0, 1'b0, r.mode, r.nvm_locked, r.acc_rd, r.acc_wr, r.bcast};
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r <= '0;
            r.mode <= MODE_BCAST_TX;
            r.nvm_record <= RECORD_INIT;
            r.shadow <= RECORD_INIT;
            r.tx_sh <= RECORD_INIT;
            r.tx_cnt <= LEN_BCAST_TX;
            r.tx_act <= 1'b1;
            r.bcast <= 1'b1;
            r.stored_secret <= SECRET_DEFAULT;
        end
        else
            r <= r_nxt;
    end

    assign reg_rdata_out = r.rdata;
    assign tx_active_out = r.tx_act;
    assign tx_bit_out = r.tx_sh[127];
    assign broadcast_mode_out = r.bcast;
    assign access_write_out = r.acc_wr;
    assign access_read_out = r.acc_rd;
    assign record_locked_out = r.nvm_locked;
    assign irq_out = r.irq;

    // Checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n);

    a_write_stores: assert property (
        (r.mode == MODE_EXEC && r.hdr[5:0] == CMD_WRITE_RECORD && !r.hdr[FLAG_CRC_POS]
         && !r.hdr[FLAG_UID_POS] && r.rx_cnt == 8'h8b && !r.nvm_locked && !r.rx_ovf
         && !field_entry_in)
        |=> (r.nvm_record == $past(r.pl[127:0])) && tx_active_out && !tx_bit_out)
        else $error("record write not stored");
    a_lock_code: assert property (
        (r.mode == MODE_EXEC && r.hdr[5:0] == CMD_WRITE_RECORD_LOCK && !r.hdr[FLAG_UID_POS]
         && r.rx_cnt == (r.hdr[FLAG_CRC_POS] ? 8'h9b : 8'h8b) && !r.nvm_locked && !r.rx_ovf
         && (!r.hdr[FLAG_CRC_POS] || r.rx_crc == 16'h0000))
        |=> record_locked_out)
        else $error("lock code did not lock");
    a_locked_stays: assert property (
        record_locked_out |=> record_locked_out && $stable(r.nvm_record))
        else $error("locked record changed");
    a_shadow_hold: assert property (
        !field_entry_in |=> $stable(r.shadow))
        else $error("broadcast copy changed without field entry");
    a_field_bcast: assert property (
        field_entry_in |=> r.mode == MODE_BCAST_TX && tx_active_out && broadcast_mode_out
        && r.tx_cnt == LEN_BCAST_TX)
        else $error("field entry did not start broadcast");
    a_sof_switch: assert property (
        (r.mode == MODE_LISTEN && sof_in && !field_entry_in)
        |=> r.mode == MODE_READER_IDLE && !broadcast_mode_out && r.rx_open)
        else $error("start of frame did not switch mode");
    a_crc_reject: assert property (
        (r.mode == MODE_EXEC && r.hdr[FLAG_CRC_POS] && r.rx_crc != 16'h0000 && !field_entry_in)
        |=> $stable(r.nvm_record) && tx_active_out && tx_bit_out)
        else $error("bad check value accepted");
    a_bad_secret: assert property (
        (r.mode == MODE_EXEC && r.hdr[5:0] == CMD_LOGIN && !r.hdr[FLAG_UID_POS] && !r.rx_ovf
         && r.rx_cnt == (r.hdr[FLAG_CRC_POS] ? 8'h43 : 8'h33)
         && (!r.hdr[FLAG_CRC_POS] || r.rx_crc == 16'h0000)
         && (r.hdr[FLAG_CRC_POS] ? r.pl[55:48] : r.pl[39:32]) == MAKER_CODE_FIELD
         && (r.hdr[FLAG_CRC_POS] ? r.pl[47:16] : r.pl[31:0]) != r.stored_secret)
        |=> !access_write_out && !access_read_out)
        else $error("wrong secret granted access");
    a_crc_tail: assert property (
        (r.tx_act && tx_next_in && r.tx_cnt == 8'h01 && r.tx_app && !r.tx_crc_ph
         && !field_entry_in)
        |=> r.tx_crc_ph && r.tx_cnt == LEN_CRC && tx_active_out)
        else $error("check value not appended");
    a_irq_level: assert property (
        irq_out == |(r.sts & r.ien))
        else $error("interrupt level mismatch");

    c_write_ok: cover property (r.mode == MODE_EXEC ##1 r.sts[EV_WRITE_DONE]);
    c_login_ok: cover property (r.mode == MODE_EXEC ##1 access_write_out);
    c_switch: cover property (r.mode == MODE_LISTEN && sof_in);
    c_sysinfo: cover property (r.tx_act && r.tx_cnt == LEN_SYSINFO_TX);
endmodule : rtcc_core
`default_nettype wire

// ### hw/rtcc_pkg.sv
// Shared constants and types of the tag command and check-value logic
package rtcc_pkg;
    // Clock and timing
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned LISTEN_TIME_US = 5000;
    localparam int unsigned LISTEN_CYCLES = (LISTEN_TIME_US * (CLK_HZ / 1_000_000));
    localparam int unsigned WRITE_RESPONSE_WAIT_MS = 20;
    // Request layout
    localparam int unsigned HDR_BITS = 11;
    localparam int unsigned FLAG_UID_POS = 10;
    localparam int unsigned FLAG_CRC_POS = 8;
    localparam int unsigned PL_BITS = 144;
    localparam logic [7:0] MAX_REQ_BITS = 8'h9b;
    localparam logic [7:0] LEN_HDR = 8'h0b;
    localparam logic [7:0] LEN_UID = 8'h30;
    localparam logic [7:0] LEN_CRC = 8'h10;
    localparam logic [7:0] LEN_RECORD = 8'h80;
    localparam logic [7:0] LEN_LOGIN = 8'h28;
    localparam logic [7:0] LEN_BCAST_TX = 8'h80;
    localparam logic [7:0] LEN_SYSINFO_TX = 8'h69;
    localparam logic [7:0] LEN_STATUS_TX = 8'h01;
    // Command codes
    localparam logic [5:0] CMD_WRITE_RECORD = 6'h38;
    localparam logic [5:0] CMD_WRITE_RECORD_LOCK = 6'h39;
    localparam logic [5:0] CMD_SYSTEM_INFO = 6'h17;
    localparam logic [5:0] CMD_LOGIN = 6'h28;
    localparam logic [5:0] CMD_MODE_SWITCH = 6'h3f;
    // Check value
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_PRESET = 16'h0000;
    // Non-volatile defaults
    localparam logic [31:0] SECRET_DEFAULT = 32'h0fffffff;
    localparam logic [127:0] RECORD_DEFAULT = 128'h0;
    // Register map (byte addresses)
    localparam logic [4:0] REG_CONTROL = 5'h00;
    localparam logic [4:0] REG_STATUS = 5'h04;
    localparam logic [4:0] REG_IRQ_ENABLE = 5'h08;
    localparam logic [4:0] REG_IRQ_CLEAR = 5'h0c;
    localparam logic [4:0] REG_STATE = 5'h10;
    localparam int unsigned CTL_CHECK_APPEND = 0;
    localparam int unsigned CTL_GRANT_READ = 1;
    localparam int unsigned EV_WRITE_DONE = 0;
    localparam int unsigned EV_LOGIN_OK = 1;
    localparam int unsigned EV_REQ_ERROR = 2;
    localparam int unsigned EV_MODE_SWITCH = 3;

    typedef enum logic [2:0] {
        MODE_BCAST_TX,
        MODE_LISTEN,
        MODE_READER_IDLE,
        MODE_EXEC,
        MODE_RESPOND
    } rtcc_mode_type;

    typedef struct packed {
        rtcc_mode_type mode;
        logic rx_open;
        logic rx_ovf;
        logic [7:0] rx_cnt;
        logic [10:0] hdr;
        logic [143:0] pl;
        logic [15:0] rx_crc;
        logic [127:0] nvm_record;
        logic nvm_locked;
        logic [31:0] stored_secret;
        logic [127:0] shadow;
        logic acc_wr;
        logic acc_rd;
        logic [127:0] tx_sh;
        logic [7:0] tx_cnt;
        logic [15:0] tx_crc;
        logic tx_crc_ph;
        logic tx_app;
        logic tx_act;
        logic [19:0] listen_cnt;
        logic bcast;
        logic check_append_flag;
        logic ctl_grant_read;
        logic [3:0] sts;
        logic [3:0] ien;
        logic irq;
        logic [31:0] rdata;
    } rtcc_st_type;
endpackage : rtcc_pkg

// ### dv/rtcc_reader_model.sv
// Reader/writer model: sends request frames and consumes answer bits
`timescale 1ns/1ns
`default_nettype none
module rtcc_reader_model
(
    input wire logic clk_in,
    input wire logic tx_active_in,
    input wire logic tx_bit_in,
    output logic sof_out,
    output logic eof_out,
    output logic rx_valid_out,
    output logic rx_bit_out,
    output logic tx_next_out
);
    initial
    begin
        sof_out = 1'b0;
        eof_out = 1'b0;
        rx_valid_out = 1'b0;
        rx_bit_out = 1'b0;
        tx_next_out = 1'b0;
    end

    // Frame is sof, bits first-bit-first (v[n-1] first), then eof
    task automatic send(input logic [255:0] v, input int n);
        @(posedge clk_in);
        sof_out <= 1'b1;
        @(posedge clk_in);
        sof_out <= 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            rx_valid_out <= 1'b1;
            rx_bit_out <= v[i];
            @(posedge clk_in);
        end
        rx_valid_out <= 1'b0;
        rx_bit_out <= ~v[0];
        eof_out <= 1'b1;
        @(posedge clk_in);
        eof_out <= 1'b0;
    endtask : send

    // Waits up to 100 cycles for the answer, then takes bits at a random pace
    task automatic get_rsp(output logic [255:0] r, output int n);
        int w;
        r = '0;
        n = 0;
        w = 0;
        #1;
        while (!tx_active_in && w < 100)
        begin
            @(posedge clk_in);
            #1;
            w++;
        end
        while (tx_active_in && n < 250)
        begin
            r = {r[254:0], tx_bit_in};
            n++;
            @(posedge clk_in);
            tx_next_out <= 1'b1;
            @(posedge clk_in);
            tx_next_out <= 1'b0;
            repeat ($urandom_range(2, 0)) @(posedge clk_in);
            #1;
        end
    endtask : get_rsp
endmodule : rtcc_reader_model
`default_nettype wire

// ### dv/tb_rfid_tag_cmd_and_crc_logic.sv
// Self-checking bench of the tag command and check-value logic
`timescale 1ns/1ns
`default_nettype none
module tb_rfid_tag_cmd_and_crc_logic;
    import rtcc_pkg::*;
    localparam logic [127:0] REC0 = 128'h8000_4e3a_19c2_0f55_aa01_7733_c0de_1234;
    localparam logic [39:0] SER = 40'h12_3456_789a; // Arbitrary value
    localparam logic [7:0] MAKER = 8'h5a; // Arbitrary value
    localparam logic [7:0] CHREF = 8'h01; // Arbitrary value
    logic clk = 1'b0, resetn = 1'b0, field = 1'b0, wr = 1'b0, rd = 1'b0, cta = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [31:0] wdata = 32'h0, rdat;
    logic sof, eof, rxv, rxb, txn, txa, txb, bmode, accw, accr, locked, irq;
    logic [31:0] rdata;
    logic [255:0] rsp;
    logic [127:0] rec;
    int rn, n_mismatch = 0, num_checks = 0, cycles = 0;

    always #10 clk = ~clk;

    rtcc_core #(.LISTEN_CYC(20), .SERIAL_NUMBER_FIELD(SER), .MAKER_CODE_FIELD(MAKER),
        .CHIP_REFERENCE_FIELD(CHREF), .RECORD_INIT(REC0)) i_rtcc_core (
        .core_clk_in(clk), .resetn_in(resetn), .field_entry_in(field), .sof_in(sof),
        .eof_in(eof), .rx_bit_valid_in(rxv), .rx_bit_in(rxb), .tx_next_in(txn),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .tx_active_out(txa), .tx_bit_out(txb),
        .broadcast_mode_out(bmode), .access_write_out(accw), .access_read_out(accr),
        .record_locked_out(locked), .irq_out(irq));

    rtcc_reader_model i_rtcc_reader_model (.clk_in(clk), .tx_active_in(txa), .tx_bit_in(txb),
        .sof_out(sof), .eof_out(eof), .rx_valid_out(rxv), .rx_bit_out(rxb), .tx_next_out(txn));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            n_mismatch++;
            $display("ERROR t=%0t run hung", $time);
            report_and_stop();
        end
    end

    task automatic chk(input logic [255:0] got, input logic [255:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t %s", $time, what);
        end
    endtask : chk

    function automatic logic [15:0] crc16(logic [255:0] v, int n);
        logic [15:0] c;
        c = CRC_PRESET;
        for (int i = n - 1; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ v[i]) ? CRC_POLY : 16'h0000);
        return c;
    endfunction : crc16

    task automatic reg_wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [4:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        rdat = rdata;
    endtask : reg_rd

    // Builds a request, optionally with a check value (corrupted when bad), and collects the answer
    task automatic xact(input logic crc, input logic bad, input logic [5:0] cmd,
        input logic [127:0] f, input int w);
        logic [255:0] v;
        int n;
        v = {245'h0, 2'b00, crc, 2'b00, cmd};
        v = (v << w) | ({128'h0, f} & ((256'h1 << w) - 1));
        n = 11 + w;
        if (crc)
        begin
            v = (v << 16) | {240'h0, crc16(v, n) ^ {15'h0, bad}};
            n += 16;
        end
        i_rtcc_reader_model.send(v, n);
        i_rtcc_reader_model.get_rsp(rsp, rn);
    endtask : xact

    task automatic exp_rsp(input logic [255:0] d, input int dn);
        int k;
        k = cta ? 16 : 0;
        chk(rn, dn + k, "answer length");
        chk(rsp >> k, d, "answer data");
        if (cta)
            chk(crc16(rsp, rn), 16'h0, "answer check value");
    endtask : exp_rsp

    initial
    begin
        void'($urandom(32'h5489));
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        chk(bmode, 1'b1, "broadcast after reset");
        i_rtcc_reader_model.get_rsp(rsp, rn);
        chk({rn, rsp[127:0]}, {32'h80, REC0}, "broadcast record");
        // No request inside the window: the record goes out again
        repeat (25) @(posedge clk);
        i_rtcc_reader_model.get_rsp(rsp, rn);
        chk({rn, rsp[127:0]}, {32'h80, REC0}, "broadcast repeats after window");
        xact(1'b0, 1'b0, CMD_SYSTEM_INFO, 128'h0, 0);
        chk(bmode, 1'b0, "switch to reader mode");
        exp_rsp({1'b0, SER, MAKER, CHREF, 48'h0}, 105);
        reg_wr(REG_CONTROL, 32'h3);
        reg_rd(REG_CONTROL);
        chk(rdat, 32'h3, "control readback");
        reg_rd(5'h1c);
        chk(rdat, 32'h0, "unmapped read");
        cta = 1'b1;
        xact(1'b1, 1'b0, CMD_SYSTEM_INFO, 128'h0, 0);
        exp_rsp({1'b0, SER, MAKER, CHREF, 48'h0}, 105);
        reg_wr(REG_IRQ_CLEAR, 32'hf);
        reg_wr(REG_STATUS, 32'hf);
        reg_wr(REG_IRQ_ENABLE, 32'h4);
        reg_rd(REG_STATUS);
        chk({rdat, irq}, 33'h0, "status cleared, read-only");
        xact(1'b1, 1'b1, CMD_SYSTEM_INFO, 128'h0, 0);
        exp_rsp(1'b1, 1);
        reg_rd(REG_STATUS);
        chk({rdat[2], irq}, 2'b11, "request error event");
        reg_wr(REG_IRQ_CLEAR, 32'h4);
        @(posedge clk);
        #1;
        chk(irq, 1'b0, "interrupt cleared");
        xact(1'b1, 1'b0, CMD_LOGIN, {MAKER, SECRET_DEFAULT ^ 32'h1}, 40);
        exp_rsp(1'b1, 1);
        chk({accw, accr}, 2'b00, "no access on wrong secret");
        xact(1'b1, 1'b0, CMD_LOGIN, {MAKER, SECRET_DEFAULT}, 40);
        exp_rsp(1'b0, 1);
        chk({accw, accr}, 2'b11, "access granted");
        xact(1'b1, 1'b0, CMD_LOGIN, {MAKER, ~SECRET_DEFAULT}, 40);
        chk({accw, accr}, 2'b00, "access withdrawn");
        for (int k = 0; k < 2; k++)
        begin
            rec = {$urandom, $urandom, $urandom, $urandom};
            xact(k[0], 1'b0, k ? CMD_WRITE_RECORD_LOCK : CMD_WRITE_RECORD, rec, 128);
            exp_rsp(1'b0, 1);
            chk({locked, bmode}, {k[0], 1'b0}, "lock and mode after write");
            @(posedge clk);
            field <= 1'b1;
            @(posedge clk);
            field <= 1'b0;
            i_rtcc_reader_model.get_rsp(rsp, rn);
            chk({rn, rsp[127:0]}, {32'h80, rec}, "new record broadcast");
            xact(1'b1, 1'b0, CMD_MODE_SWITCH, 128'h0, 0);
            chk({rn, bmode}, 33'h0, "switch command, no answer");
        end
        xact(1'b1, 1'b0, CMD_WRITE_RECORD, ~rec, 128);
        exp_rsp(1'b1, 1);
        report_and_stop();
    end
endmodule : tb_rfid_tag_cmd_and_crc_logic
`default_nettype wire
